// File: rtl/stm_pkg.sv
/*
 * Shared constants and types of the compare-match timer: register map,
 * control field layout, operating mode and output action codes.
 * Assumes an 8-bit register port with a 4-bit address.
 */
package stcm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map.
    localparam logic [3:0] ADDR_CNT_LO = 4'h0;
    localparam logic [3:0] ADDR_CNT_HI = 4'h1;
    localparam logic [3:0] ADDR_CMPA_LO = 4'h2;
    localparam logic [3:0] ADDR_CMPA_HI = 4'h3;
    localparam logic [3:0] ADDR_CMPP = 4'h4;
    localparam logic [3:0] ADDR_RUN = 4'h5;
    localparam logic [3:0] ADDR_CTRL = 4'h6;
    localparam logic [3:0] ADDR_FLAGS = 4'h7;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int RUN_BIT = 0;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] P_LOW_BYTE = 8'h00;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    localparam int TICK_DIV_DEF = 1;

    ////////////////////////////////////////////////////////////////////////
    // Modes, output actions and the control register layout.
    typedef enum logic [1:0] {
        MODE_CMP = 2'b00,
        MODE_RSV = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TC = 2'b11
    } stcm_mode_type;

    typedef enum logic [1:0] {
        ACT_HOLD = 2'b00,
        ACT_LOW = 2'b01,
        ACT_HIGH = 2'b10,
        ACT_TOGGLE = 2'b11
    } stcm_act_type;

    // Bits 7:6 mode, 5:4 action, 3 initial level, 2 invert, 0 clear select.
    typedef struct packed {
        stcm_mode_type mode;
        stcm_act_type act;
        logic init_level;
        logic invert;
        logic spare;
        logic clr_sel;
    } stcm_ctrl_type;

    localparam stcm_ctrl_type CTRL_RST = '{MODE_CMP, ACT_HOLD, 1'b0, 1'b0,
        1'b0, 1'b0};

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } stcm_bus_type;

endpackage : stcm_pkg

// File: rtl/stm_timer.sv
/*
 * Compare-match timer: 16-bit up counter, compare A and compare P,
 * match flags and output pin actions, plus an 8-bit register port.
 * Assumes a synchronous register master that uses one-cycle strobes.
 */
`timescale 1ns/1ps

module stcm_timer #(
    parameter int TICK_DIV = stcm_pkg::TICK_DIV_DEF
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port.
    input wire stcm_pkg::stcm_bus_type bus_i,
    output logic [7:0] rdata_o,
    // Output pin.
    output logic timer_pin_o,
    output logic timer_pin_oe_n_o,
    // Status.
    output logic compare_a_flag_o,
    output logic compare_p_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // State.
    logic [15:0] count;
    logic [15:0] next_count;
    logic [15:0] compare_a_value;
    logic [15:0] next_compare_a_value;
    logic [7:0] compare_p_value;
    logic [7:0] next_compare_p_value;
    stcm_pkg::stcm_ctrl_type ctrl;
    stcm_pkg::stcm_ctrl_type next_ctrl;
    logic timer_run;
    logic next_timer_run;
    logic run_q;
    logic next_run_q;
    logic flag_a;
    logic next_flag_a;
    logic flag_p;
    logic next_flag_p;
    logic out_level;
    logic next_out_level;
    logic pin;
    logic next_pin;
    logic pin_oe_n;
    logic next_pin_oe_n;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;

    logic tick;
    logic run_rise;
    logic step;
    logic cmp_mode;
    logic a_hit;
    logic p_hit;
    logic a_set;
    logic p_set;
    logic clr_now;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.
    function automatic logic is_wr(input stcm_pkg::stcm_bus_type b,
                                   input logic [3:0] a);
        is_wr = b.wr && (b.addr == a);
    endfunction : is_wr

    ////////////////////////////////////////////////////////////////////////
    // Match decode.
    always_comb begin
        tick = (div_cnt == 16'(TICK_DIV - 1));
        run_rise = timer_run && !run_q;
        step = timer_run && tick && !run_rise;
        cmp_mode = (ctrl.mode == stcm_pkg::MODE_CMP) ||
                   (ctrl.mode == stcm_pkg::MODE_TC);
        // The P match fires on the last count before the high byte reaches
        // the programmed value, so a value of zero lands on FFFF.
        p_hit = ((count + stcm_pkg::CNT_STEP) ==
                 {compare_p_value, stcm_pkg::P_LOW_BYTE});
        a_hit = (count == compare_a_value) &&
                (compare_a_value != stcm_pkg::RST_WORD);
        a_set = step && cmp_mode && a_hit;
        p_set = step && cmp_mode && !ctrl.clr_sel && p_hit;
        // Outside the compare modes the counter simply wraps.
        clr_now = cmp_mode && (ctrl.clr_sel ? a_hit : p_hit);
    end

    ////////////////////////////////////////////////////////////////////////
    // Divider and counter.
    always_comb begin
        next_div_cnt = tick ? stcm_pkg::RST_WORD : div_cnt + 16'h0001;
        next_run_q = timer_run;
        next_count = count;
        if (run_rise) begin
            next_count = stcm_pkg::RST_WORD;
        end else if (step) begin
            next_count = clr_now ? stcm_pkg::RST_WORD :
                         count + stcm_pkg::CNT_STEP;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_cnt <= stcm_pkg::RST_WORD;
            run_q <= 1'b0;
            count <= stcm_pkg::RST_WORD;
        end else begin
            div_cnt <= next_div_cnt;
            run_q <= next_run_q;
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers and flags.
    always_comb begin
        next_compare_a_value = compare_a_value;
        next_compare_p_value = compare_p_value;
        next_ctrl = ctrl;
        next_timer_run = timer_run;
        next_flag_a = flag_a;
        next_flag_p = flag_p;
        if (is_wr(bus_i, stcm_pkg::ADDR_CMPA_LO)) begin
            next_compare_a_value[7:0] = bus_i.wdata;
        end
        if (is_wr(bus_i, stcm_pkg::ADDR_CMPA_HI)) begin
            next_compare_a_value[15:8] = bus_i.wdata;
        end
        if (is_wr(bus_i, stcm_pkg::ADDR_CMPP)) begin
            next_compare_p_value = bus_i.wdata;
        end
        if (is_wr(bus_i, stcm_pkg::ADDR_RUN)) begin
            next_timer_run = bus_i.wdata[stcm_pkg::RUN_BIT];
        end
        if (is_wr(bus_i, stcm_pkg::ADDR_CTRL)) begin
            next_ctrl = stcm_pkg::stcm_ctrl_type'(bus_i.wdata);
        end
        // Write one to clear; a match in the same cycle keeps the flag.
        if (is_wr(bus_i, stcm_pkg::ADDR_FLAGS)) begin
            next_flag_a = flag_a && !bus_i.wdata[stcm_pkg::FLAG_A_BIT];
            next_flag_p = flag_p && !bus_i.wdata[stcm_pkg::FLAG_P_BIT];
        end
        if (a_set) begin
            next_flag_a = 1'b1;
        end
        if (p_set) begin
            next_flag_p = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            compare_a_value <= stcm_pkg::RST_WORD;
            compare_p_value <= stcm_pkg::RST_BYTE;
            ctrl <= stcm_pkg::CTRL_RST;
            timer_run <= 1'b0;
            flag_a <= 1'b0;
            flag_p <= 1'b0;
        end else begin
            compare_a_value <= next_compare_a_value;
            compare_p_value <= next_compare_p_value;
            ctrl <= next_ctrl;
            timer_run <= next_timer_run;
            flag_a <= next_flag_a;
            flag_p <= next_flag_p;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output level and pin.
    always_comb begin
        next_out_level = out_level;
        if (run_rise) begin
            next_out_level = ctrl.init_level;
        end else if (a_set && ctrl.mode == stcm_pkg::MODE_CMP) begin
            unique case (ctrl.act)
                stcm_pkg::ACT_HOLD: next_out_level = out_level;
                stcm_pkg::ACT_LOW: next_out_level = 1'b0;
                stcm_pkg::ACT_HIGH: next_out_level = 1'b1;
                stcm_pkg::ACT_TOGGLE: next_out_level = !out_level;
            endcase
        end
        // The pin is released in every mode but compare mode so it can serve as
        // general I/O; the invert bit then has nothing to act on.
        next_pin_oe_n = (ctrl.mode != stcm_pkg::MODE_CMP);
        next_pin = next_pin_oe_n ? 1'b0 :
                   next_out_level ^ ctrl.invert;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_level <= 1'b0;
            pin <= 1'b0;
            pin_oe_n <= 1'b0;
        end else begin
            out_level <= next_out_level;
            pin <= next_pin;
            pin_oe_n <= next_pin_oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data stands only in the cycle after the strobe.
    always_comb begin
        next_rdata = stcm_pkg::RST_BYTE;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                stcm_pkg::ADDR_CNT_LO: next_rdata = count[7:0];
                stcm_pkg::ADDR_CNT_HI: next_rdata = count[15:8];
                stcm_pkg::ADDR_CMPA_LO: next_rdata = compare_a_value[7:0];
                stcm_pkg::ADDR_CMPA_HI: next_rdata = compare_a_value[15:8];
                stcm_pkg::ADDR_CMPP: next_rdata = compare_p_value;
                stcm_pkg::ADDR_RUN: next_rdata = {7'h00, timer_run};
                stcm_pkg::ADDR_CTRL: next_rdata = 8'(ctrl);
                stcm_pkg::ADDR_FLAGS: next_rdata = {6'h00, flag_p, flag_a};
                default: next_rdata = stcm_pkg::RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata <= stcm_pkg::RST_BYTE;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign rdata_o = rdata;
    assign timer_pin_o = pin;
    assign timer_pin_oe_n_o = pin_oe_n;
    assign compare_a_flag_o = flag_a;
    assign compare_p_flag_o = flag_p;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_clear_on_p;
        @(posedge clk_i) disable iff (sys_rst_i)
        (step && cmp_mode && !ctrl.clr_sel && p_hit) |=> (count == 16'h0000);
    endproperty
    a_clear_on_p: assert property (p_clear_on_p)
        else $error("Counter not cleared on compare P match.");

    property p_clear_on_a;
        @(posedge clk_i) disable iff (sys_rst_i)
        (step && cmp_mode && ctrl.clr_sel && a_hit) |=>
            (count == 16'h0000 && flag_a);
    endproperty
    a_clear_on_a: assert property (p_clear_on_a)
        else $error("Counter or A flag wrong on compare A match.");

    property p_no_p_flag_csel;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ctrl.clr_sel && !flag_p && !is_wr(bus_i, stcm_pkg::ADDR_CTRL)) |=>
            !flag_p;
    endproperty
    a_no_p_flag_csel: assert property (p_no_p_flag_csel)
        else $error("Compare P flag rose with clear select high.");

    property p_no_a_flag_zero;
        @(posedge clk_i) disable iff (sys_rst_i)
        (compare_a_value == 16'h0000 && !flag_a) |=> !flag_a;
    endproperty
    a_no_a_flag_zero: assert property (p_no_a_flag_zero)
        else $error("Compare A flag rose with compare A zero.");

    property p_overflow_p_zero;
        @(posedge clk_i) disable iff (sys_rst_i)
        (step && compare_p_value == 8'h00 && count == 16'hFFFF) |=>
            (count == 16'h0000);
    endproperty
    a_overflow_p_zero: assert property (p_overflow_p_zero)
        else $error("Counter did not wrap at FFFF.");

    property p_pin_cause;
        @(posedge clk_i) disable iff (sys_rst_i)
        !$stable(out_level) |-> $past(a_set) || $past(run_rise);
    endproperty
    a_pin_cause: assert property (p_pin_cause)
        else $error("Output level changed without an A match or start.");

    property p_toggle;
        @(posedge clk_i) disable iff (sys_rst_i)
        (a_set && !run_rise && ctrl.mode == stcm_pkg::MODE_CMP &&
         ctrl.act == stcm_pkg::ACT_TOGGLE) |=> (out_level != $past(out_level));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("Output did not toggle on compare A match.");

    property p_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        (a_set && !run_rise && ctrl.act == stcm_pkg::ACT_HOLD) |=>
            $stable(out_level);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Output moved with action zero.");

    property p_start_level;
        @(posedge clk_i) disable iff (sys_rst_i)
        run_rise |=> (out_level == $past(ctrl.init_level)) &&
                     (count == 16'h0000);
    endproperty
    a_start_level: assert property (p_start_level)
        else $error("Start did not load the initial output level.");

    property p_pin_invert;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ctrl.mode == stcm_pkg::MODE_CMP && $stable(ctrl)) |=>
            (timer_pin_o == (out_level ^ $past(ctrl.invert))) &&
            !timer_pin_oe_n_o;
    endproperty
    a_pin_invert: assert property (p_pin_invert)
        else $error("Pin level does not follow output level and invert.");

    property p_read_count;
        @(posedge clk_i) disable iff (sys_rst_i)
        (bus_i.rd && bus_i.addr == stcm_pkg::ADDR_CNT_HI) |=>
            (rdata_o == $past(count[15:8]));
    endproperty
    a_read_count: assert property (p_read_count)
        else $error("Counter high byte read back wrong.");

endmodule : stcm_timer

// File: test/tb_stm_timer.sv
/*
 * Self-checking bench for the compare-match timer: register reads are
 * queued and compared by a monitor, pin timing is measured directly.
 * Assumes the register map and control layout of the timer package.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    fail_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb_stcm_timer;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    stcm_pkg::stcm_bus_type bus_i = '0;
    logic [7:0] rdata_o;
    logic timer_pin_o;
    logic timer_pin_oe_n_o;
    logic compare_a_flag_o;
    logic compare_p_flag_o;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    integer seed = 32'he8a43ffc;
    logic [7:0] exp_q[$];
    logic rd_d1 = 1'b0;
    logic [7:0] ra;
    logic [7:0] na;
    logic hold;
    logic [7:0] exp_v;

    stcm_timer #(.TICK_DIV(1)) u_stcm_timer (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .timer_pin_o(timer_pin_o), .timer_pin_oe_n_o(timer_pin_oe_n_o),
        .compare_a_flag_o(compare_a_flag_o),
        .compare_p_flag_o(compare_p_flag_o));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
    endtask : rd

    // Cycles until the pin changes; bounded so a stuck pin cannot hang.
    task automatic wait_edge(output int k);
        logic p;
        p = timer_pin_o;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (timer_pin_o === p && k < 70000);
    endtask : wait_edge

    function automatic logic [7:0] ctl(input logic [1:0] m,
        input logic [1:0] act, input logic il, input logic inv,
        input logic cs);
        return {m, act, il, inv, 1'b0, cs};
    endfunction : ctl

    ////////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe.
    always @(posedge clk_i) begin
        if (rd_d1 && exp_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            `CHK("rdata", exp_v, rdata_o)
        end
        rd_d1 <= bus_i.rd;
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        wr(stcm_pkg::ADDR_CNT_LO, 8'hFF);
        wr(stcm_pkg::ADDR_CNT_HI, 8'hFF);
        for (int a = 0; a < 8; a++) begin
            rd(a[3:0], 8'h00);
        end
        rd(4'h9, 8'h00);
        for (int i = 0; i < 3; i++) begin
            ra = $random(seed);
            wr(stcm_pkg::ADDR_CMPA_LO, ra);
            wr(stcm_pkg::ADDR_CMPA_HI, ~ra);
            wr(stcm_pkg::ADDR_CMPP, ra ^ 8'h5A);
            rd(stcm_pkg::ADDR_CMPA_LO, ra);
            rd(stcm_pkg::ADDR_CMPA_HI, ~ra);
            rd(stcm_pkg::ADDR_CMPP, ra ^ 8'h5A);
        end
        // Clear on A with P below A: period A+1, no P flag.
        na = 8'h03 + ($random(seed) & 8'h07);
        wr(stcm_pkg::ADDR_CMPA_LO, na);
        wr(stcm_pkg::ADDR_CMPA_HI, 8'h02);
        wr(stcm_pkg::ADDR_CMPP, 8'h01);
        wr(stcm_pkg::ADDR_CTRL, ctl(stcm_pkg::MODE_CMP, stcm_pkg::ACT_TOGGLE,
            1'b1, 1'b0, 1'b1));
        wr(stcm_pkg::ADDR_RUN, 8'h01);
        repeat (3) @(posedge clk_i);
        `CHK("pin_init_high", 1'b1, timer_pin_o)
        `CHK("oe_n_cmp", 1'b0, timer_pin_oe_n_o)
        wait_edge(n);
        wait_edge(n);
        `CHK("a_period", 32'h201 + na, n)
        `CHK("flag_a", 1'b1, compare_a_flag_o)
        `CHK("flag_p_never", 1'b0, compare_p_flag_o)
        rd(stcm_pkg::ADDR_FLAGS, 8'h01);
        wr(stcm_pkg::ADDR_CTRL, ctl(stcm_pkg::MODE_CMP, stcm_pkg::ACT_HOLD,
            1'b1, 1'b0, 1'b1));
        hold = timer_pin_o;
        repeat (1100) @(posedge clk_i);
        `CHK("pin_hold", hold, timer_pin_o)
        wr(stcm_pkg::ADDR_CTRL, ctl(stcm_pkg::MODE_CMP, stcm_pkg::ACT_LOW,
            1'b1, 1'b0, 1'b1));
        repeat (600) @(posedge clk_i);
        `CHK("pin_low", 1'b0, timer_pin_o)
        wr(stcm_pkg::ADDR_CTRL, ctl(stcm_pkg::MODE_CMP, stcm_pkg::ACT_HIGH,
            1'b1, 1'b0, 1'b1));
        repeat (600) @(posedge clk_i);
        `CHK("pin_high", 1'b1, timer_pin_o)
        wr(stcm_pkg::ADDR_RUN, 8'h00);
        // Clear on P with inverted pin; P matches must not move the pin.
        wr(stcm_pkg::ADDR_FLAGS, 8'h03);
        wr(stcm_pkg::ADDR_CMPA_LO, 8'h05);
        wr(stcm_pkg::ADDR_CMPA_HI, 8'h00);
        wr(stcm_pkg::ADDR_CTRL, ctl(stcm_pkg::MODE_CMP, stcm_pkg::ACT_TOGGLE,
            1'b0, 1'b1, 1'b0));
        wr(stcm_pkg::ADDR_RUN, 8'h01);
        repeat (3) @(posedge clk_i);
        `CHK("pin_init_inv", 1'b1, timer_pin_o)
        wait_edge(n);
        wait_edge(n);
        `CHK("p1_period", 32'd256, n)
        wr(stcm_pkg::ADDR_CMPP, 8'h02);
        wait_edge(n);
        wait_edge(n);
        wait_edge(n);
        `CHK("p2_period", 32'd512, n)
        rd(stcm_pkg::ADDR_FLAGS, 8'h03);
        wr(stcm_pkg::ADDR_RUN, 8'h00);
        // Waveform mode ignores clear select and releases the pin.
        wr(stcm_pkg::ADDR_FLAGS, 8'h03);
        wr(stcm_pkg::ADDR_CTRL, ctl(stcm_pkg::MODE_PWM, stcm_pkg::ACT_TOGGLE,
            1'b0, 1'b0, 1'b1));
        wr(stcm_pkg::ADDR_RUN, 8'h01);
        repeat (600) @(posedge clk_i);
        `CHK("oe_n_pwm", 1'b1, timer_pin_oe_n_o)
        rd(stcm_pkg::ADDR_FLAGS, 8'h00);
        wr(stcm_pkg::ADDR_RUN, 8'h00);
        // Zero compare values are left to the pin-less mode only.
        wr(stcm_pkg::ADDR_FLAGS, 8'h03);
        wr(stcm_pkg::ADDR_CMPA_LO, 8'h00);
        wr(stcm_pkg::ADDR_CMPP, 8'h00);
        wr(stcm_pkg::ADDR_CTRL, ctl(stcm_pkg::MODE_TC, stcm_pkg::ACT_TOGGLE,
            1'b0, 1'b0, 1'b0));
        wr(stcm_pkg::ADDR_RUN, 8'h01);
        `CHK("oe_n_tc", 1'b1, timer_pin_oe_n_o)
        n = 0;
        while (compare_p_flag_o !== 1'b1 && n < 70000) begin
            @(posedge clk_i);
            n++;
        end
        `CHK("overflow", 1'b1, n >= 65534 && n <= 65539)
        `CHK("flag_a_zero", 1'b0, compare_a_flag_o)
        repeat (4) @(posedge clk_i);
        results();
    end
endmodule : tb_stcm_timer
